/* core/cdr_pkg.sv */
// Constants and register map for the capture DMA request block
package cdr_pkg;

  // Channel and pair counts
  localparam int NUM_CH      = 6;
  localparam int NUM_PAIR    = 3;
  localparam int CNT_W       = 16;
  localparam int DATA_W      = 32;
  localparam int ADDR_W      = 12;
  localparam int FIFO_DEPTH  = 16;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] RISING_VALUE_BASE  = 12'h20C;
  localparam logic [ADDR_W-1:0] FALLING_VALUE_BASE = 12'h210;
  localparam logic [ADDR_W-1:0] VALUE_STRIDE       = 12'h008;
  localparam logic [ADDR_W-1:0] CONTROL_OFFSET     = 12'h23C;
  localparam logic [ADDR_W-1:0] PAIR_DATA_BASE     = 12'h240;
  localparam logic [ADDR_W-1:0] PAIR_DATA_STRIDE   = 12'h004;
  localparam logic [ADDR_W-1:0] DMA_STATUS_OFFSET  = 12'h24C;
  localparam logic [ADDR_W-1:0] FLAG_OFFSET        = 12'h254;

  // Control field layout, per pair at base + 8 * pair
  localparam int PAIR_FIELD_STRIDE = 8;
  localparam int ENABLE_BIT        = 0;
  localparam int EDGE_SEL_LSB      = 1;
  localparam int ORDER_BIT         = 3;
  localparam int CHAN_SEL_BIT      = 4;
  localparam int PAIR_FIELD_W      = 5;

  // Flag register layout
  localparam int RISE_FLAG_LSB = 0;
  localparam int FALL_FLAG_LSB = 8;

  // Status register layout
  localparam int PENDING_LSB = 0;
  localparam int OVERRUN_LSB = 4;

  // Reset values
  localparam logic [DATA_W-1:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  VALUE_RESET   = 16'h0000;

  // Edge select codes
  typedef enum logic [1:0] {
    CDR_EDGE_NONE    = 2'b00,
    CDR_EDGE_RISING  = 2'b01,
    CDR_EDGE_FALLING = 2'b10,
    CDR_EDGE_BOTH    = 2'b11
  } cdr_edge_t;

endpackage : cdr_pkg

/* core/cdr_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cdr_fifo
  import cdr_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0]   FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_SLOT  = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Handshake terms
  assign in_ready  = (count != FULL_COUNT);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage write
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers with wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  // Fill level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end

endmodule // cdr_fifo
`default_nettype wire

/* core/cdr_capture_dma.sv */
// Capture edge detection and DMA request logic with APB registers
// Function
// - With a pair's enable bit set, each qualifying capture event on it that finds room in the pair's FIFO leads to a DMA request.
// - Each pair has a readable 16-bit buffer holding the value waiting for DMA.
// - A two-bit field per pair chooses rising data, falling data or both.
// - Field value 3 moves both the rising and falling values of the served channel.
// - With both edges moved, an order bit per pair picks which edge goes first.
// - Order bit 1 presents the rising value first and then the falling value.
// - The two channels of a pair share one DMA channel chosen by a select bit.
// - Select bit 0 serves the even channel of the pair.
// - Rising-first drops a falling edge with no rising edge ahead of it; after a rising edge it moves the falling value too.
// - A rising input edge latches the counter into the rising value, a falling edge the falling.
// - Hardware sets the rising or falling flag on an edge; software clears it by writing one.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cdr_capture_dma
  import cdr_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [ADDR_W-1:0]             paddr,
  input  wire logic [DATA_W-1:0]             pwdata,
  output logic      [DATA_W-1:0]             prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [NUM_CH-1:0]             capture_in,
  input  wire logic [NUM_CH-1:0][CNT_W-1:0]  channel_count,
  output logic      [NUM_PAIR-1:0]           dma_req,
  input  wire logic [NUM_PAIR-1:0]           dma_ack
);

  // Pin synchronisers and edge state
  logic [NUM_CH-1:0] sync1;
  logic [NUM_CH-1:0] sync2;
  logic [NUM_CH-1:0] sync3;
  logic [NUM_CH-1:0] level;
  logic [NUM_CH-1:0] change;
  logic [NUM_CH-1:0] rise_ev;
  logic [NUM_CH-1:0] fall_ev;

  // Capture values and flags
  logic [CNT_W-1:0]  rising_capture_value  [NUM_CH];
  logic [CNT_W-1:0]  falling_capture_value [NUM_CH];
  logic [NUM_CH-1:0] rising_capture_flag;
  logic [NUM_CH-1:0] falling_capture_flag;

  // Control and DMA state
  logic [DATA_W-1:0]   capture_dma_control;
  logic [CNT_W-1:0]    capture_dma_buffer [NUM_PAIR];
  logic [NUM_PAIR-1:0] expect_second;
  logic [NUM_PAIR-1:0] overrun;
  logic [NUM_PAIR-1:0] push_valid;
  logic [NUM_PAIR-1:0] push_ready;
  logic [CNT_W-1:0]    push_data [NUM_PAIR];
  logic [NUM_PAIR-1:0] next_expect;
  logic [NUM_PAIR-1:0] pop_valid;
  logic [CNT_W-1:0]    pop_data [NUM_PAIR];

  // APB access terms
  logic              access;
  logic              wr_en;
  logic              rd_hit;
  logic [DATA_W-1:0] rd_word;

  // Field extraction for one pair
  function automatic logic [PAIR_FIELD_W-1:0] pair_field(input logic [DATA_W-1:0] ctl,
                                                         input int p);
    pair_field = ctl[p*PAIR_FIELD_STRIDE +: PAIR_FIELD_W];
  endfunction

  // Served channel index of one pair
  function automatic int served_channel(input logic [DATA_W-1:0] ctl, input int p);
    logic [PAIR_FIELD_W-1:0] f;
    f = pair_field(ctl, p);
    served_channel = 2 * p + (f[CHAN_SEL_BIT] ? 1 : 0);
  endfunction

  // Three-stage pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= capture_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Edge counts once stages two and three agree
  assign change  = ~(sync2 ^ sync3) & (sync3 ^ level);
  assign rise_ev = change & sync3;
  assign fall_ev = change & ~sync3;

  // Filtered input level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= '0;
    end else begin
      level <= level ^ change;
    end
  end

  // Counter latch per channel
  for (genvar c = 0; c < NUM_CH; c++) begin : g_latch
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rising_capture_value[c]  <= VALUE_RESET;
        falling_capture_value[c] <= VALUE_RESET;
      end else begin
        if (rise_ev[c]) begin
          rising_capture_value[c] <= channel_count[c];
        end
        if (fall_ev[c]) begin
          falling_capture_value[c] <= channel_count[c];
        end
      end
    end
  end

  // APB decode; write takes effect in the cycle pready is high
  assign access = psel & penable & pready;
  assign wr_en  = access & pwrite;

  // Capture flags, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rising_capture_flag  <= '0;
      falling_capture_flag <= '0;
    end else if (wr_en && paddr == FLAG_OFFSET) begin
      rising_capture_flag  <= (rising_capture_flag & ~pwdata[RISE_FLAG_LSB +: NUM_CH])
                              | rise_ev;
      falling_capture_flag <= (falling_capture_flag & ~pwdata[FALL_FLAG_LSB +: NUM_CH])
                              | fall_ev;
    end else begin
      rising_capture_flag  <= rising_capture_flag | rise_ev;
      falling_capture_flag <= falling_capture_flag | fall_ev;
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_dma_control <= CONTROL_RESET;
    end else if (wr_en && paddr == CONTROL_OFFSET) begin
      capture_dma_control <= pwdata;
    end
  end

  // Qualify edges of the served channel into FIFO pushes
  always_comb begin
    for (int p = 0; p < NUM_PAIR; p++) begin
      logic [PAIR_FIELD_W-1:0] f;
      cdr_edge_t               mode;
      int                      ch;
      f             = pair_field(capture_dma_control, p);
      mode          = cdr_edge_t'(f[EDGE_SEL_LSB +: 2]);
      ch            = served_channel(capture_dma_control, p);
      push_valid[p] = 1'b0;
      push_data[p]  = rising_capture_value[ch];
      next_expect[p] = expect_second[p];
      if (f[ENABLE_BIT]) begin
        unique case (mode)
          CDR_EDGE_NONE: begin
            push_valid[p] = 1'b0;
          end
          CDR_EDGE_RISING: begin
            push_valid[p] = rise_ev[ch];
            push_data[p]  = channel_count[ch];
          end
          CDR_EDGE_FALLING: begin
            push_valid[p] = fall_ev[ch];
            push_data[p]  = channel_count[ch];
          end
          CDR_EDGE_BOTH: begin
            // First edge of the order always starts a sequence
            if (f[ORDER_BIT] ? rise_ev[ch] : fall_ev[ch]) begin
              push_valid[p]  = 1'b1;
              push_data[p]   = channel_count[ch];
              next_expect[p] = 1'b1;
            end else if ((f[ORDER_BIT] ? fall_ev[ch] : rise_ev[ch]) && expect_second[p]) begin
              push_valid[p]  = 1'b1;
              push_data[p]   = channel_count[ch];
              next_expect[p] = 1'b0;
            end
            // A second-kind edge with no first edge ahead of it is dropped
          end
        endcase
      end else begin
        next_expect[p] = 1'b0;
      end
    end
  end

  // Pair FIFOs and DMA buffers
  for (genvar p = 0; p < NUM_PAIR; p++) begin : g_pair
    cdr_fifo #(
      .WIDTH (CNT_W),
      .DEPTH (DEPTH)
    ) u_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (push_valid[p]),
      .in_ready  (push_ready[p]),
      .in_data   (push_data[p]),
      .out_valid (pop_valid[p]),
      .out_ready (!dma_req[p]),
      .out_data  (pop_data[p])
    );

    // Buffer load and request hold until acknowledge
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        capture_dma_buffer[p] <= VALUE_RESET;
        dma_req[p]            <= 1'b0;
      end else if (dma_req[p]) begin
        if (dma_ack[p]) begin
          dma_req[p] <= 1'b0;
        end
      end else if (pop_valid[p]) begin
        capture_dma_buffer[p] <= pop_data[p];
        dma_req[p]            <= 1'b1;
      end
    end

    // Sequence state and FIFO overrun
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        expect_second[p] <= 1'b0;
        overrun[p]       <= 1'b0;
      end else begin
        expect_second[p] <= next_expect[p];
        if (push_valid[p] && !push_ready[p]) begin
          overrun[p] <= 1'b1;
        end else if (wr_en && paddr == DMA_STATUS_OFFSET
                     && pwdata[OVERRUN_LSB + p]) begin
          overrun[p] <= 1'b0;
        end
      end
    end
  end

  // Read mux over the register map
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (paddr == RISING_VALUE_BASE + ADDR_W'(c) * VALUE_STRIDE) begin
        rd_word = {{(DATA_W-CNT_W){1'b0}}, rising_capture_value[c]};
        rd_hit  = 1'b1;
      end
      if (paddr == FALLING_VALUE_BASE + ADDR_W'(c) * VALUE_STRIDE) begin
        rd_word = {{(DATA_W-CNT_W){1'b0}}, falling_capture_value[c]};
        rd_hit  = 1'b1;
      end
    end
    for (int p = 0; p < NUM_PAIR; p++) begin
      if (paddr == PAIR_DATA_BASE + ADDR_W'(p) * PAIR_DATA_STRIDE) begin
        rd_word = {{(DATA_W-CNT_W){1'b0}}, capture_dma_buffer[p]};
        rd_hit  = 1'b1;
      end
    end
    if (paddr == CONTROL_OFFSET) begin
      rd_word = capture_dma_control;
      rd_hit  = 1'b1;
    end
    if (paddr == FLAG_OFFSET) begin
      rd_word[RISE_FLAG_LSB +: NUM_CH] = rising_capture_flag;
      rd_word[FALL_FLAG_LSB +: NUM_CH] = falling_capture_flag;
      rd_hit  = 1'b1;
    end
    if (paddr == DMA_STATUS_OFFSET) begin
      rd_word[PENDING_LSB +: NUM_PAIR] = dma_req;
      rd_word[OVERRUN_LSB +: NUM_PAIR] = overrun;
      rd_hit  = 1'b1;
    end
  end

  // APB slave: one wait state, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? '0 : rd_word;
      pslverr <= !rd_hit;
    end else begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_req_hold: assert property (dma_req[0] && !dma_ack[0] |=> dma_req[0])
    else $error("request dropped before acknowledge");
  a_buf_stable: assert property (dma_req[1] && !dma_ack[1] |=> $stable(capture_dma_buffer[1]))
    else $error("buffer overwritten while pending");
  a_ack_release: assert property (dma_req[2] && dma_ack[2] |=> !dma_req[2])
    else $error("request not released after acknowledge");
  a_rise_latch: assert property (rise_ev[0] |=> rising_capture_value[0] == $past(channel_count[0]))
    else $error("rising value not latched");
  a_fall_latch: assert property (fall_ev[3] |=> falling_capture_value[3] == $past(channel_count[3]))
    else $error("falling value not latched");
  a_flag_set: assert property (rise_ev[1] |=> rising_capture_flag[1])
    else $error("rising flag not set on edge");
  a_flag_clear: assert property (wr_en && paddr == FLAG_OFFSET && pwdata[FALL_FLAG_LSB]
                                 && !fall_ev[0] |=> !falling_capture_flag[0])
    else $error("falling flag not cleared by write one");
  a_pin_to_edge: assert property (!sync2[2] && !sync3[2] && $past(sync3[2])
                                  && $past(sync3[2], 2) |-> fall_ev[2])
    else $error("agreed falling level missed");
  a_disabled_quiet: assert property (!capture_dma_control[ENABLE_BIT] |-> !push_valid[0])
    else $error("push from disabled pair");
  a_req_follows_push: assert property (push_valid[0] && push_ready[0] && !dma_req[0]
                                       && !pop_valid[0] |=> ##1 dma_req[0])
    else $error("no request after capture");
  a_rise_first: assert property (capture_dma_control[EDGE_SEL_LSB +: 2] == 2'b11
                                 && capture_dma_control[ORDER_BIT] && !expect_second[0]
                                 && !capture_dma_control[CHAN_SEL_BIT]
                                 && fall_ev[0] |-> !push_valid[0])
    else $error("falling value moved ahead of rising");

  c_req_ack: cover property (dma_req[0] ##[1:20] dma_ack[0]);
  c_both_edges: cover property (push_valid[0] && capture_dma_control[EDGE_SEL_LSB +: 2] == 2'b11
                                ##[1:200] push_valid[0]);
  c_odd_served: cover property (capture_dma_control[CHAN_SEL_BIT] && push_valid[0]);
  c_overrun: cover property (overrun[0]);

endmodule // cdr_capture_dma
`default_nettype wire

/* tb/cdr_dma_model.sv */
// Behavioural DMA controller that moves pair buffers over APB and acknowledges
`timescale 1ns/1ps
`default_nettype none
module cdr_dma_model
  import cdr_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                active,
  input  wire logic [2:0]          stall,
  input  wire logic                pready,
  input  wire logic [DATA_W-1:0]   prdata,
  output logic                     psel,
  output logic                     penable,
  output logic      [ADDR_W-1:0]   paddr,
  input  wire logic [NUM_PAIR-1:0] dma_req,
  output logic      [NUM_PAIR-1:0] dma_ack
);
  // Words delivered to memory, pair number above the value
  logic [17:0] got[$];

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    paddr   = '0;
    dma_ack = '0;
  end

  // Serve the lowest pending pair: read its buffer, store it, then acknowledge
  always begin : serve
    int p;
    @(posedge pclk);
    if (presetn && active && |dma_req) begin
      p = 0;
      while (!dma_req[p]) p++;
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= PAIR_DATA_BASE + PAIR_DATA_STRIDE * ADDR_W'(p);
      @(posedge pclk);
      penable <= 1'b1;
      do begin
        @(posedge pclk);
      end while (pready !== 1'b1);
      got.push_back({2'(p), prdata[15:0]});
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~paddr; // Released address does not keep its value
      repeat (stall) @(posedge pclk);
      dma_ack[p] <= 1'b1;
      @(posedge pclk);
      dma_ack[p] <= 1'b0;
    end
  end
endmodule // cdr_dma_model
`default_nettype wire

/* tb/cdr_capture_dma_tb.sv */
// Self-checking testbench for the capture DMA request block
`timescale 1ns/1ps
`default_nettype none
module cdr_capture_dma_tb;
  import cdr_pkg::*;
  logic                          pclk = 1'b0;
  logic                          presetn = 1'b0;
  logic                          dma_on = 1'b0;
  logic                          t_psel = 1'b0;
  logic                          t_penable = 1'b0;
  logic                          t_pwrite = 1'b0;
  logic [ADDR_W-1:0]             t_paddr = '0;
  logic [DATA_W-1:0]             t_pwdata = '0;
  logic                          m_psel;
  logic                          m_penable;
  logic [ADDR_W-1:0]             m_paddr;
  logic                          psel;
  logic                          penable;
  logic                          pwrite;
  logic [ADDR_W-1:0]             paddr;
  logic [DATA_W-1:0]             pwdata;
  logic [DATA_W-1:0]             prdata;
  logic                          pready;
  logic                          pslverr;
  logic [NUM_CH-1:0]             capture_in = '0;
  logic [NUM_CH-1:0][CNT_W-1:0]  channel_count = '0;
  logic [NUM_PAIR-1:0]           dma_req;
  logic [NUM_PAIR-1:0]           dma_ack;
  logic [2:0]                    stall = 3'h0;
  integer                        seed = 32'h3A17;
  int                            fails = 0;
  int                            n_checks = 0;
  int                            cycles = 0;
  logic [17:0]                   exp_q[$];

  always #5 pclk = ~pclk;

  // Bus goes to the DMA model while it owns the transfers
  assign psel    = dma_on ? m_psel : t_psel;
  assign penable = dma_on ? m_penable : t_penable;
  assign pwrite  = dma_on ? 1'b0 : t_pwrite;
  assign paddr   = dma_on ? m_paddr : t_paddr;
  assign pwdata  = dma_on ? 32'h0000_0000 : t_pwdata;

  cdr_capture_dma #(.DEPTH(2)) i_cdr_capture_dma (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_in(capture_in), .channel_count(channel_count), .dma_req(dma_req),
    .dma_ack(dma_ack));

  cdr_dma_model i_cdr_dma_model (
    .pclk(pclk), .presetn(presetn), .active(dma_on), .stall(stall), .pready(pready),
    .prdata(prdata), .psel(m_psel), .penable(m_penable), .paddr(m_paddr),
    .dma_req(dma_req), .dma_ack(dma_ack));

  task automatic print_verdict;
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    t_psel    <= 1'b1;
    t_penable <= 1'b0;
    t_pwrite  <= wr;
    t_paddr   <= a;
    t_pwdata  <= wd;
    @(posedge pclk);
    t_penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    t_psel    <= 1'b0;
    t_penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rdc(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk(what, exp, rd);
    chk("slave error", 32'(1'b0), 32'(err));
  endtask

  // New random count on a channel, then one edge on its pin
  task automatic toggle(input int c, output logic [15:0] v);
    @(posedge pclk);
    v = 16'($random(seed));
    channel_count[c] <= v;
    @(posedge pclk);
    capture_in[c] <= ~capture_in[c];
    repeat (12) @(posedge pclk);
  endtask

  // Let the DMA model empty the pair and compare what reached memory
  task automatic drain;
    int w;
    @(posedge pclk);
    dma_on <= 1'b1;
    w = 0;
    while ((i_cdr_dma_model.got.size() < exp_q.size() || dma_req !== '0) && w < 800) begin
      @(posedge pclk);
      w++;
    end
    repeat (20) @(posedge pclk);
    chk("dma word count", exp_q.size(), i_cdr_dma_model.got.size());
    for (int k = 0; k < exp_q.size() && k < i_cdr_dma_model.got.size(); k++)
      chk("dma word", 32'(exp_q[k]), 32'(i_cdr_dma_model.got[k]));
    dma_on <= 1'b0;
    i_cdr_dma_model.got.delete();
    exp_q.delete();
  endtask

  function automatic logic [31:0] ctl(input int p, input int en, input int m, input int o,
                                      input int s);
    return 32'({s[0], o[0], m[1:0], en[0]}) << (PAIR_FIELD_STRIDE * p);
  endfunction

  // Whether an edge is moved, given mode, order and the pending first edge
  function automatic logic keep(input int m, input int o, input logic r, inout int arm);
    if (m == 1) return r;
    if (m == 2) return !r;
    if (m != 3) return 1'b0;
    if (r == o[0]) begin
      arm = 1;
      return 1'b1;
    end
    if (arm == 1) begin
      arm = 0;
      return 1'b1;
    end
    return 1'b0;
  endfunction

  // Cycle ceiling against hangs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin : main
    logic [31:0] rd;
    logic        err;
    logic [15:0] v;
    logic [15:0] rv;
    logic [15:0] fv;
    int          p;
    int          c;
    int          m;
    int          o;
    int          s;
    int          en;
    int          arm;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped access
    rdc("control reset", CONTROL_OFFSET, CONTROL_RESET);
    rdc("status reset", DMA_STATUS_OFFSET, 32'h0000_0000);
    rdc("flag reset", FLAG_OFFSET, 32'h0000_0000);
    rdc("buffer reset", PAIR_DATA_BASE, 32'h0000_0000);
    apb(1'b0, 12'hFF0, 32'h0000_0000, rd, err);
    chk("unmapped error", 32'h0000_0001, 32'(err));
    // Capture values and flags on every channel
    for (c = 0; c < NUM_CH; c++) begin
      toggle(c, rv);
      toggle(c, fv);
      rdc("rising value", RISING_VALUE_BASE + VALUE_STRIDE * ADDR_W'(c), 32'(rv));
      rdc("falling value", FALLING_VALUE_BASE + VALUE_STRIDE * ADDR_W'(c), 32'(fv));
      rdc("flags set", FLAG_OFFSET, (32'h1 << c) | (32'h100 << c));
      wr(FLAG_OFFSET, 32'h1 << c);
      rdc("rising flag clear", FLAG_OFFSET, 32'h100 << c);
      wr(FLAG_OFFSET, 32'h100 << c);
      rdc("falling flag clear", FLAG_OFFSET, 32'h0000_0000);
    end
    // Every edge mode and order, pairs in turn, random served channel except channel 0 for rising-first on pair 0, last one disabled
    for (int i = 0; i < 9; i++) begin
      p = (i + 2) % 3;
      s = (i == 7) ? 0 : {$random(seed)} % 2;
      m = (i == 8) ? 3 : i / 2;
      o = i % 2;
      en = (i != 8);
      c = 2 * p + s;
      arm = 0;
      toggle(c, v); // Served pin high first, so the run opens on a falling edge
      wr(CONTROL_OFFSET, ctl(p, en, m, o, s));
      stall <= 3'($random(seed));
      dma_on <= 1'b1;
      for (int k = 0; k < 4; k++) begin
        toggle(c ^ 1, v);
        toggle(c, v);
        if (en == 1 && keep(m, o, (k % 2) == 1, arm)) exp_q.push_back({2'(p), v});
      end
      drain();
      wr(CONTROL_OFFSET, 32'h0000_0000);
      toggle(c, v);
    end
    // Fill the two-deep FIFO past full while the DMA stays away, then drain with stalls
    wr(CONTROL_OFFSET, ctl(1, 1, 1, 0, 0));
    stall <= 3'h7;
    for (int k = 0; k < 4; k++) begin
      toggle(2, v);
      if (k < 3) exp_q.push_back({2'(1), v});
      toggle(2, fv);
    end
    chk("request held", 32'h0000_0002, 32'(dma_req));
    rdc("pending and overrun", DMA_STATUS_OFFSET, 32'h0000_0022);
    rdc("pair buffer", PAIR_DATA_BASE + PAIR_DATA_STRIDE, 32'(exp_q[0][15:0]));
    drain();
    wr(DMA_STATUS_OFFSET, 32'h0000_0020);
    rdc("overrun clear", DMA_STATUS_OFFSET, 32'h0000_0000);
    print_verdict();
  end
endmodule // cdr_capture_dma_tb
`default_nettype wire
